// ===== acs_pkg.sv
package acs_pkg;
	// Special-function address of the converter status register
	localparam logic [7:0] ACS_STATUS_ADDR = 8'hF5;
	// Power-on value of the status register
	localparam logic [7:0] ACS_STATUS_RESET = 8'h00;
	// Position of the busy flag
	localparam int ACS_BUSY_BIT = 7;
	// Fixed conversion length in converter clocks
	localparam logic [4:0] ACS_CONV_CLOCKS = 5'h0F;
	// Synchronisation clocks ahead of acquisition
	localparam logic [4:0] ACS_SYNC_CLOCKS = 5'h01;
	// Result width of the approximation register
	localparam int ACS_RES_W = 12;

	// Sequencer phases
	typedef enum logic [1:0] {
		ACS_IDLE = 2'b00,
		ACS_SYNC = 2'b01,
		ACS_ACQ = 2'b10,
		ACS_CONV = 2'b11
	} acs_phase_t;

	// Start request carrier
	typedef struct packed {
		logic start;
		logic calib;
		logic [1:0] acqSel;
	} acs_req_t;

	// Special-function register bus carrier
	typedef struct packed {
		logic [7:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} acs_sfr_t;
endpackage : acs_pkg

// ===== acs_adc_status.sv
// Function
// R01 - Status register at F5H, 8 bits, resets zero
// R02 - Bit 7 busy, read-only, set during cycles
// R03 - Busy clears itself when cycle completes
// R04 - Bits 0-6 reserved, read zero
// R05 - Sample then convert; latch final approximation
// R06 - Sequencing automatic, acquisition length configurable
// R07 - Conversion: 15 clocks, sync, acquisition
// R08 - Busy from acquisition start to latch
`timescale 1ns/1ps
module acs_adc_status
	import acs_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic adcClkEn,
	input wire acs_req_t req,
	input wire acs_sfr_t sfr,
	input wire logic cmpHigh,
	output logic [7:0] sfrRdata,
	output logic sfrRvalid,
	output logic [ACS_RES_W-1:0] result,
	output logic resultValid,
	output logic trackHold
);
	// Sequencer phase, current and next
	acs_phase_t phase, next_phase;
	// Converter ticks left in the current phase
	logic [4:0] count, next_count;
	// Working approximation register
	logic [ACS_RES_W-1:0] sar, next_sar;
	// Single trial bit, walks from the top bit down
	logic [ACS_RES_W-1:0] trial, next_trial;
	// Calibration cycle flag, no result latched for it
	logic calRun, next_calRun;
	// Busy flag, owned by hardware only
	logic busy, next_busy;
	// Next values of the registered read port
	logic [7:0] next_sfrRdata;
	logic next_sfrRvalid;
	// Next values of the result port
	logic [ACS_RES_W-1:0] next_result;
	logic next_resultValid;
	// Next value of the track switch
	logic next_trackHold;

	// Status byte: busy on top, reserved bits zero
	function automatic logic [7:0] statusByte(input logic b);
		logic [7:0] v;
		v = ACS_STATUS_RESET; // R04
		v[ACS_BUSY_BIT] = b; // R02
		return v;
	endfunction : statusByte

	// Acquisition ticks for a selector code, one to four
	function automatic logic [4:0] acqTicks(input logic [1:0] sel);
		// Code zero still gives one tick of tracking
		return {3'h0, sel} + 5'h01; // R07
	endfunction : acqTicks

	// True on the final tick of a counted phase
	function automatic logic lastTick(input logic [4:0] c);
		return c == 5'h01;
	endfunction : lastTick

	// Sequencer next state: phase, counter, busy and track
	always_comb begin
		// Hold everything between converter ticks
		next_phase = phase;
		next_count = count;
		next_calRun = calRun;
		next_busy = busy;
		next_trackHold = trackHold;
		// Sequencer only moves on a converter tick
		if (adcClkEn) begin
			case (phase)
				ACS_IDLE: begin
					// Starts only taken here, a start while busy is lost
					if (req.start) begin
						next_phase = ACS_SYNC; // R06
						next_count = ACS_SYNC_CLOCKS; // R07
						next_calRun = req.calib;
					end
				end
				ACS_SYNC: begin
					// One tick to line up with the converter clock
					next_phase = ACS_ACQ;
					// Selector read here; software keeps it steady
					next_count = acqTicks(req.acqSel); // R07
					next_busy = 1'b1; // R08
					next_trackHold = 1'b1; // R05
				end
				ACS_ACQ: begin
					if (lastTick(count)) begin
						// Switch to hold and start resolving
						next_phase = ACS_CONV; // R05
						next_count = ACS_CONV_CLOCKS; // R07
						next_trackHold = 1'b0;
					end else begin
						// Still tracking the input
						next_count = count - 5'h01;
					end
				end
				ACS_CONV: begin
					if (lastTick(count)) begin
						// Cycle over, busy drops with no software help
						next_phase = ACS_IDLE;
						next_busy = 1'b0; // R03
					end else begin
						// Resolution steps still running
						next_count = count - 5'h01;
					end
				end
				default: begin
					// Unused code: fall back to idle, not busy
					next_phase = ACS_IDLE;
					next_busy = 1'b0;
					next_trackHold = 1'b0;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			// Reset drops any cycle in flight
			phase <= ACS_IDLE;
			count <= 5'h00;
			calRun <= 1'b0;
			busy <= 1'b0; // R01
			trackHold <= 1'b0;
		end else begin
			// Ticks gate the next values, not the clock
			phase <= next_phase;
			count <= next_count;
			calRun <= next_calRun;
			busy <= next_busy;
			trackHold <= next_trackHold;
		end
	end

	// Approximation and result next state
	always_comb begin
		next_sar = sar;
		next_trial = trial;
		next_result = result;
		// Result strobe lasts one clock only
		next_resultValid = 1'b0;
		if (adcClkEn) begin
			case (phase)
				ACS_ACQ: begin
					if (lastTick(count)) begin
						// Clear the register and aim at the top bit
						next_sar = ACS_RES_W'(0);
						next_trial = {1'b1, {(ACS_RES_W-1){1'b0}}};
					end
				end
				ACS_CONV: begin
					// One decision per tick while trial bits last
					if (trial != ACS_RES_W'(0)) begin
						// Comparator high means the trial overshot
						next_sar = cmpHigh ? sar : (sar | trial); // R05
						next_trial = trial >> 1;
					end
					// Calibration runs the same steps, keeps no result
					if (lastTick(count) && !calRun) begin
						next_result = sar; // R05
						next_resultValid = 1'b1; // R08
					end
				end
				default: begin
					// Nothing to resolve outside the conversion
					next_sar = sar;
				end
			endcase
		end
	end

	// Approximation and result registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			// No stale result survives a reset
			sar <= ACS_RES_W'(0);
			trial <= ACS_RES_W'(0);
			result <= ACS_RES_W'(0);
			resultValid <= 1'b0;
		end else begin
			// Result holds between conversions
			sar <= next_sar;
			trial <= next_trial;
			result <= next_result;
			resultValid <= next_resultValid;
		end
	end

	// Status read decode
	always_comb begin
		// Writes change nothing: busy is hardware-owned and the
		// reserved bits have no storage behind them
		// Only a read of the status address is answered
		next_sfrRvalid = sfr.rd && (sfr.addr == ACS_STATUS_ADDR); // R01
		// Busy as of the cycle in which the read is taken
		next_sfrRdata = next_sfrRvalid ? statusByte(busy) : 8'h00; // R02
	end

	// Read port registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			// Power-on value seen on the read port
			sfrRdata <= ACS_STATUS_RESET;
			sfrRvalid <= 1'b0;
		end else begin
			// Data is zero whenever no read is answered
			sfrRdata <= next_sfrRdata;
			sfrRvalid <= next_sfrRvalid;
		end
	end
endmodule : acs_adc_status

// ===== acs_adc_status_asserts.sv
`timescale 1ns/1ps
module acs_adc_status_asserts
	import acs_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic adcClkEn,
	input wire acs_sfr_t sfr,
	input wire logic [7:0] sfrRdata,
	input wire logic sfrRvalid,
	input wire logic resultValid,
	input wire logic trackHold
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Status read request
	sequence s_rd; sfr.rd && sfr.addr == ACS_STATUS_ADDR; endsequence
	property p_rv; s_rd |=> sfrRvalid; endproperty
	a_rv: assert property (p_rv) else $error("no valid");
	property p_nv; !(sfr.rd && sfr.addr == ACS_STATUS_ADDR) |=> !sfrRvalid;
	endproperty
	a_nv: assert property (p_nv) else $error("stray valid");
	property p_lo; sfrRvalid |-> sfrRdata[6:0] == 7'h00; endproperty
	a_lo: assert property (p_lo) else $error("low bits");
	property p_id; !sfrRvalid |-> sfrRdata == 8'h00; endproperty
	a_id: assert property (p_id) else $error("idle data");
	property p_bz; s_rd ##0 trackHold |=> sfrRdata[7]; endproperty
	a_bz: assert property (p_bz) else $error("busy");
	property p_pv; resultValid |=> !resultValid; endproperty
	a_pv: assert property (p_pv) else $error("pulse");
	property p_th; trackHold |-> !resultValid; endproperty
	a_th: assert property (p_th) else $error("track");
	property p_rt; $rose(trackHold) |-> $past(adcClkEn); endproperty
	a_rt: assert property (p_rt) else $error("tick");
endmodule : acs_adc_status_asserts
bind acs_adc_status acs_adc_status_asserts u_chk (
	.clock(clock),
	.resetn(resetn),
	.adcClkEn(adcClkEn),
	.sfr(sfr),
	.sfrRdata(sfrRdata),
	.sfrRvalid(sfrRvalid),
	.resultValid(resultValid),
	.trackHold(trackHold)
);

// ===== acs_adc_status_tb_top.sv
`timescale 1ns/1ps
module acs_adc_status_tb_top
	import acs_pkg::*;
();
	logic clock = 0, resetn = 0, adcClkEn = 0, cmpHigh = 0;
	acs_req_t req = '0;
	acs_sfr_t sfr = '0;
	logic [7:0] sfrRdata, d;
	logic sfrRvalid, resultValid, trackHold;
	logic [11:0] result;
	int err_total = 0, checks_done = 0, n, i, hits;
	// Code the comparator steers the converter to
	localparam logic [11:0] SAR_CODE = 12'hA5C;
	always #10 clock = ~clock;
	acs_adc_status dut (
		.clock(clock),
		.resetn(resetn),
		.adcClkEn(adcClkEn),
		.req(req),
		.sfr(sfr),
		.cmpHigh(cmpHigh),
		.sfrRdata(sfrRdata),
		.sfrRvalid(sfrRvalid),
		.result(result),
		.resultValid(resultValid),
		.trackHold(trackHold)
	);
	task chk(input string w, input logic [11:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", w, e, s);
		end
	endtask : chk
	task conclude;
		$display("checks %0d bad %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	// Status read, data taken while valid stands
	task rd;
		@(negedge clock) sfr.addr = ACS_STATUS_ADDR;
		sfr.rd = 1;
		@(negedge clock) sfr.rd = 0;
		chk("vld", 12'(sfrRvalid), 12'h001);
		d = sfrRdata;
	endtask : rd
	// Write busy high, reserved bits zero; must read back zero
	task t_idle;
		@(negedge clock) sfr = '{8'hF5, 1'b0, 1'b1, 8'h80};
		@(negedge clock) sfr.wr = 0;
		rd;
		chk("idle", 12'(d), 12'h000);
		$display("t_idle done");
	endtask : t_idle
	// Longest acquisition, comparator never high
	task t_conv;
		@(negedge clock) adcClkEn = 1;
		req = '{1'b1, 1'b0, 2'h3};
		@(negedge clock) req.start = 0;
		for (n = 0; n < 9 && trackHold !== 1; n++) @(negedge clock);
		for (n = 0; n < 9 && trackHold === 1; n++) @(negedge clock);
		chk("acq", 12'(n), 12'h004);
		rd;
		chk("busy", 12'(d), 12'h080);
		for (n = 0; n < 30 && resultValid !== 1; n++) @(negedge clock);
		chk("rv", 12'(resultValid), 12'h001);
		chk("res", result, 12'hFFF);
		rd;
		chk("done", 12'(d), 12'h000);
		$display("t_conv done");
	endtask : t_conv
	// Shortest acquisition, comparator steers a known code
	task t_sar;
		@(negedge clock) req = '{1'b1, 1'b0, 2'h0};
		@(negedge clock) req.start = 0;
		for (n = 0; n < 9 && trackHold !== 1; n++) @(negedge clock);
		for (n = 0; n < 9 && trackHold === 1; n++) @(negedge clock);
		chk("acq1", 12'(n), 12'h001);
		// MSB first, one decision per tick; high clears the bit
		for (i = 11; i >= 0; i--) begin
			cmpHigh = ~SAR_CODE[i];
			@(negedge clock);
		end
		cmpHigh = 0;
		for (n = 0; n < 30 && resultValid !== 1; n++) @(negedge clock);
		chk("conv", 12'(n + 12), 12'h00F);
		chk("code", result, SAR_CODE);
		$display("t_sar done");
	endtask : t_sar
	// Calibration: busy shown, start refused, no result kept
	task t_cal;
		@(negedge clock) req = '{1'b1, 1'b1, 2'h1};
		@(negedge clock) req.start = 0;
		for (n = 0; n < 9 && trackHold !== 1; n++) @(negedge clock);
		// Start raised while busy must be ignored
		req.start = 1;
		rd;
		req.start = 0;
		chk("cbusy", 12'(d), 12'h080);
		chk("cacq", 12'(trackHold), 12'h000);
		hits = 0;
		for (n = 0; n < 24; n++) begin
			@(negedge clock);
			if (resultValid !== 0) hits++;
		end
		chk("cpulse", 12'(hits), 12'h000);
		chk("ckeep", result, SAR_CODE);
		rd;
		chk("cdone", 12'(d), 12'h000);
		$display("t_cal done");
	endtask : t_cal
	// Reset in mid-cycle aborts it; outputs back to zero
	task t_rst;
		@(negedge clock) req = '{1'b1, 1'b0, 2'h3};
		@(negedge clock) req.start = 0;
		for (n = 0; n < 9 && trackHold !== 1; n++) @(negedge clock);
		resetn = 0;
		repeat (2) @(negedge clock);
		resetn = 1;
		@(negedge clock);
		chk("rhold", 12'(trackHold), 12'h000);
		chk("rres", result, 12'h000);
		chk("rval", 12'({sfrRvalid, resultValid}), 12'h000);
		chk("rdat", 12'(sfrRdata), 12'h000);
		rd;
		chk("ridle", 12'(d), 12'h000);
		$display("t_rst done");
	endtask : t_rst
	initial begin
		repeat (8) @(negedge clock);
		resetn = 1;
		t_idle;
		t_conv;
		t_sar;
		t_cal;
		t_rst;
		conclude;
	end
	// Hang guard: tests need about 95 clocks, this allows 1000
	initial begin
		#20000;
		err_total++;
		conclude;
	end
endmodule : acs_adc_status_tb_top
